// file: otfs_pkg.sv
// otfs_pkg: function codes, widths and timing constants of the output terminal selector
package otfs_pkg;

   // ***************************************************************
   // sizes
   // ***************************************************************
   localparam int NUM_TERM = 9;
   localparam int CODE_W = 6;
   localparam int CNT_W = 32;
   localparam int TEMP_W = 16;
   localparam int ZC_W = 32;

   // ***************************************************************
   // function codes
   // ***************************************************************
   localparam logic [CODE_W-1:0] FC_NONE = 6'h00;
   localparam logic [CODE_W-1:0] FC_LOW_LIMIT_STOP = 6'h09;
   localparam logic [CODE_W-1:0] FC_REVERSE = 6'h0A;
   localparam logic [CODE_W-1:0] FC_ZERO_RUN = 6'h0B;
   localparam logic [CODE_W-1:0] FC_ZERO_ANY = 6'h0C;
   localparam logic [CODE_W-1:0] FC_SET_COUNT = 6'h0D;
   localparam logic [CODE_W-1:0] FC_DESIG_COUNT = 6'h0E;
   localparam logic [CODE_W-1:0] FC_LENGTH = 6'h0F;
   localparam logic [CODE_W-1:0] FC_SEQ_DONE = 6'h10;
   localparam logic [CODE_W-1:0] FC_FDT_A = 6'h11;
   localparam logic [CODE_W-1:0] FC_FDT_B = 6'h12;
   localparam logic [CODE_W-1:0] FC_FREQ_REACHED = 6'h13;
   localparam logic [CODE_W-1:0] FC_ARB_FREQ_A = 6'h14;
   localparam logic [CODE_W-1:0] FC_ARB_FREQ_B = 6'h15;
   localparam logic [CODE_W-1:0] FC_CURR_A = 6'h16;
   localparam logic [CODE_W-1:0] FC_CURR_B = 6'h17;
   localparam logic [CODE_W-1:0] FC_MODULE_TEMP = 6'h18;
   localparam logic [CODE_W-1:0] FC_TIMING = 6'h19;
   localparam logic [CODE_W-1:0] FC_ZERO_CURR = 6'h1A;
   localparam logic [CODE_W-1:0] FC_CURR_LIMIT = 6'h1B;
   localparam logic [CODE_W-1:0] FC_UNDERVOLT = 6'h1C;
   localparam logic [CODE_W-1:0] FC_DRV_OVERLOAD = 6'h1D;
   localparam logic [CODE_W-1:0] FC_MOTOR_HOT = 6'h1E;
   localparam logic [CODE_W-1:0] FC_MOTOR_OVERLOAD = 6'h1F;
   localparam logic [CODE_W-1:0] FC_OFF_LOAD = 6'h20;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int SEQ_PULSE_MS = 250;
   // exact: 250 ms at 100 ns
   localparam int SEQ_PULSE_CYC = SEQ_PULSE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int PULSE_W = 22;

endpackage

// file: otfs_pulse_stretch.sv
// otfs_pulse_stretch: turns a cycle-complete strobe into a fixed-width pulse
`timescale 1ns/1ns
module otfs_pulse_stretch #(
   parameter logic [otfs_pkg::PULSE_W-1:0] WIDTH = otfs_pkg::PULSE_W'(otfs_pkg::SEQ_PULSE_CYC)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // strobe in, pulse out
   input wire logic trig,
   output logic pulse
);

   typedef struct packed {
      logic [otfs_pkg::PULSE_W-1:0] cnt;
      logic pulse;
   } otfs_ps_s;

   otfs_ps_s st_r;
   otfs_ps_s st_nxt;

   // a new completion during a pulse restarts it, so two close cycles are not lost
   always_comb begin
      st_nxt = st_r;
      if (trig) begin
         st_nxt.cnt = WIDTH - 1'b1;
         st_nxt.pulse = 1'b1;
      end else if (st_r.cnt != '0) begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end else begin
         st_nxt.pulse = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pulse = st_r.pulse;

   // pulse stands at least eight cycles after an isolated trigger
   property p_pulse_width;
      @(posedge clk) disable iff (!rst_n)
         $rose(st_r.pulse) && st_r.cnt == WIDTH - 1'b1 |-> st_r.pulse [*8];
   endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("pulse too short");

endmodule

// file: otfs_zero_curr.sv
// otfs_zero_curr: qualifies the low-current level with a programmable delay
`timescale 1ns/1ns
module otfs_zero_curr (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // level in, delay in cycles, qualified state out
   input wire logic curr_low,
   input wire logic [otfs_pkg::ZC_W-1:0] delay_cyc,
   output logic zero_state
);

   typedef struct packed {
      logic [otfs_pkg::ZC_W-1:0] cnt;
      logic state;
   } otfs_zc_s;

   otfs_zc_s st_r;
   otfs_zc_s st_nxt;

   // count time spent at or below the level; on only once it exceeds the delay
   always_comb begin
      st_nxt = st_r;
      if (!curr_low) begin
         st_nxt.cnt = '0;
         st_nxt.state = 1'b0;
      end else if (st_r.cnt > delay_cyc) begin
         st_nxt.state = 1'b1;
      end else begin
         st_nxt.cnt = st_r.cnt + 1'b1; // stops at delay+1; an all-ones delay never qualifies
      end
   end

   // state register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign zero_state = st_r.state;

   // a current rise clears the state on the next edge
   property p_zc_clear;
      @(posedge clk) disable iff (!rst_n) !curr_low |=> !st_r.state;
   endproperty
   a_zc_clear: assert property (p_zc_clear) else $error("zero current held high");

endmodule

// file: otfs_top.sv
// otfs_top: per-terminal function select for digital outputs, codes 9 to 32
`timescale 1ns/1ns
module otfs_top (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // per-terminal function codes, terminal i in bits [6i+5:6i]
   input wire logic [otfs_pkg::NUM_TERM*otfs_pkg::CODE_W-1:0] func_code,
   // drive run state
   input wire logic running,
   input wire logic reverse,
   input wire logic at_lower_limit,
   input wire logic out_freq_zero,
   input wire logic undervolt,
   // counter and length
   input wire logic [otfs_pkg::CNT_W-1:0] count_value,
   input wire logic [otfs_pkg::CNT_W-1:0] set_count_target,
   input wire logic [otfs_pkg::CNT_W-1:0] designated_count_target,
   input wire logic [otfs_pkg::CNT_W-1:0] actual_length,
   input wire logic [otfs_pkg::CNT_W-1:0] length_target,
   // sequencer strobe, one cycle when the simple_step_sequencer ends a cycle
   input wire logic seq_cycle_done,
   // frequency and current detectors
   input wire logic freq_level_detector_a,
   input wire logic freq_level_detector_b,
   input wire logic freq_reached,
   input wire logic arb_freq_reached_a,
   input wire logic arb_freq_reached_b,
   input wire logic curr_reached_a,
   input wire logic curr_reached_b,
   input wire logic curr_limit_exceeded,
   // zero current level compare and qualify delay
   input wire logic curr_at_or_below_zero_level,
   input wire logic [otfs_pkg::ZC_W-1:0] zero_curr_delay_cyc,
   // temperatures
   input wire logic [otfs_pkg::TEMP_W-1:0] heatsink_temp_reading,
   input wire logic [otfs_pkg::TEMP_W-1:0] module_temp_threshold,
   input wire logic [otfs_pkg::TEMP_W-1:0] motor_temp_monitor,
   input wire logic [otfs_pkg::TEMP_W-1:0] motor_overheat_threshold,
   // timing
   input wire logic run_timer_enable,
   input wire logic [otfs_pkg::CNT_W-1:0] run_time,
   input wire logic [otfs_pkg::CNT_W-1:0] run_time_set,
   // load
   input wire logic drive_overload_warn,
   input wire logic motor_overload_warn,
   input wire logic load_zero,
   // output terminals
   output logic [otfs_pkg::NUM_TERM-1:0] term_out
);

   // ***************************************************************
   // reset release
   // ***************************************************************
   logic [1:0] rst_sync_r;
   logic rst_n_int;

   // asynchronous assert, two-flop release so all state leaves reset together
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n_int = rst_sync_r[1];

   // ***************************************************************
   // helpers
   // ***************************************************************
   logic seq_pulse;
   logic zero_curr_state;

   otfs_pulse_stretch u_seq_pulse (
      .clk(clk),
      .rst_n(rst_n_int),
      .trig(seq_cycle_done),
      .pulse(seq_pulse)
   );

   otfs_zero_curr u_zero_curr (
      .clk(clk),
      .rst_n(rst_n_int),
      .curr_low(curr_at_or_below_zero_level),
      .delay_cyc(zero_curr_delay_cyc),
      .zero_state(zero_curr_state)
   );

   // ***************************************************************
   // condition vector, indexed by function code
   // ***************************************************************
   localparam int NCOND = 2 ** otfs_pkg::CODE_W;
   logic [NCOND-1:0] cond;

   // every code not listed here, including zero, stays low
   always_comb begin
      cond = '0;
      // stop counts as "at lower limit" for this code
      cond[otfs_pkg::FC_LOW_LIMIT_STOP] = at_lower_limit || !running;
      cond[otfs_pkg::FC_REVERSE] = running && reverse;
      cond[otfs_pkg::FC_ZERO_RUN] = running && out_freq_zero;
      cond[otfs_pkg::FC_ZERO_ANY] = out_freq_zero || !running;
      cond[otfs_pkg::FC_SET_COUNT] = count_value >= set_count_target;
      cond[otfs_pkg::FC_DESIG_COUNT] = count_value >= designated_count_target;
      cond[otfs_pkg::FC_LENGTH] = actual_length > length_target;
      cond[otfs_pkg::FC_SEQ_DONE] = seq_pulse;
      cond[otfs_pkg::FC_FDT_A] = freq_level_detector_a;
      cond[otfs_pkg::FC_FDT_B] = freq_level_detector_b;
      cond[otfs_pkg::FC_FREQ_REACHED] = freq_reached;
      cond[otfs_pkg::FC_ARB_FREQ_A] = arb_freq_reached_a;
      cond[otfs_pkg::FC_ARB_FREQ_B] = arb_freq_reached_b;
      cond[otfs_pkg::FC_CURR_A] = curr_reached_a;
      cond[otfs_pkg::FC_CURR_B] = curr_reached_b;
      cond[otfs_pkg::FC_MODULE_TEMP] =
         heatsink_temp_reading >= module_temp_threshold;
      cond[otfs_pkg::FC_TIMING] = run_timer_enable && (run_time >= run_time_set);
      cond[otfs_pkg::FC_ZERO_CURR] = zero_curr_state;
      cond[otfs_pkg::FC_CURR_LIMIT] = curr_limit_exceeded;
      cond[otfs_pkg::FC_UNDERVOLT] = undervolt;
      cond[otfs_pkg::FC_DRV_OVERLOAD] = drive_overload_warn;
      cond[otfs_pkg::FC_MOTOR_HOT] =
         motor_temp_monitor >= motor_overheat_threshold;
      cond[otfs_pkg::FC_MOTOR_OVERLOAD] = motor_overload_warn;
      cond[otfs_pkg::FC_OFF_LOAD] = load_zero;
   end

   // ***************************************************************
   // per-terminal select and output register
   // ***************************************************************
   typedef struct packed {
      logic [otfs_pkg::NUM_TERM-1:0] term;
   } otfs_top_s;

   otfs_top_s st_r;
   otfs_top_s st_nxt;
   logic [otfs_pkg::NUM_TERM-1:0] sel;

   // each terminal indexes the vector with its own code, no sharing
   genvar gi;
   generate
      for (gi = 0; gi < otfs_pkg::NUM_TERM; gi++) begin : g_term
         assign sel[gi] = cond[func_code[gi*otfs_pkg::CODE_W +: otfs_pkg::CODE_W]];
      end
   endgenerate

   // one cycle of latency; registered so the pins never glitch
   always_comb begin
      st_nxt = st_r;
      st_nxt.term = sel;
   end

   // output register
   always_ff @(posedge clk or negedge rst_n_int) begin
      if (!rst_n_int) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign term_out = st_r.term;

   // ***************************************************************
   // checks
   // ***************************************************************
   property p_code_zero_off;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_NONE |=> !term_out[0];
   endproperty
   a_code_zero_off: assert property (p_code_zero_off) else $error("code 0 drove on");

   property p_low_limit_stop;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_LOW_LIMIT_STOP && !running
         |=> term_out[0];
   endproperty
   a_low_limit_stop: assert property (p_low_limit_stop) else $error("code 9 off at stop");

   property p_zero_run_stop;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_ZERO_RUN && !running
         |=> !term_out[0];
   endproperty
   a_zero_run_stop: assert property (p_zero_run_stop) else $error("code 11 on at stop");

   property p_zero_any;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_ZERO_ANY && out_freq_zero
         |=> term_out[0];
   endproperty
   a_zero_any: assert property (p_zero_any) else $error("code 12 off at zero");

   property p_length;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_LENGTH
         |=> term_out[0] == ($past(actual_length) > $past(length_target));
   endproperty
   a_length: assert property (p_length) else $error("code 15 wrong");

   property p_timing_disabled;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_TIMING && !run_timer_enable
         |=> !term_out[0];
   endproperty
   a_timing_disabled: assert property (p_timing_disabled) else $error("code 25 on");

   property p_undervolt;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_UNDERVOLT
         |=> term_out[0] == $past(undervolt);
   endproperty
   a_undervolt: assert property (p_undervolt) else $error("code 28 wrong");

   property p_unassigned_off;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] > otfs_pkg::FC_OFF_LOAD |=> !term_out[0];
   endproperty
   a_unassigned_off: assert property (p_unassigned_off) else $error("unassigned on");

   property p_independent;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W +: otfs_pkg::CODE_W] == otfs_pkg::FC_REVERSE
         |=> term_out[1] == ($past(running) && $past(reverse));
   endproperty
   a_independent: assert property (p_independent) else $error("terminal 1 wrong");

   property p_reverse;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_REVERSE
         |=> term_out[0] == ($past(running) && $past(reverse));
   endproperty
   a_reverse: assert property (p_reverse) else $error("code 10 wrong");

   property p_set_count;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_SET_COUNT
         |=> term_out[0] == ($past(count_value) >= $past(set_count_target));
   endproperty
   a_set_count: assert property (p_set_count) else $error("code 13 wrong");

   property p_desig_count;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_DESIG_COUNT
         |=> term_out[0] == ($past(count_value) >= $past(designated_count_target));
   endproperty
   a_desig_count: assert property (p_desig_count) else $error("code 14 wrong");

   property p_seq_done;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_SEQ_DONE
         |=> term_out[0] == $past(seq_pulse);
   endproperty
   a_seq_done: assert property (p_seq_done) else $error("code 16 wrong");

   property p_module_temp;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_MODULE_TEMP
         |=> term_out[0] == ($past(heatsink_temp_reading) >= $past(module_temp_threshold));
   endproperty
   a_module_temp: assert property (p_module_temp) else $error("code 24 wrong");

   property p_zero_curr;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_ZERO_CURR
         |=> term_out[0] == $past(zero_curr_state);
   endproperty
   a_zero_curr: assert property (p_zero_curr) else $error("code 26 wrong");

   property p_curr_limit;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_CURR_LIMIT
         |=> term_out[0] == $past(curr_limit_exceeded);
   endproperty
   a_curr_limit: assert property (p_curr_limit) else $error("code 27 wrong");

   property p_motor_hot;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_MOTOR_HOT
         |=> term_out[0] == ($past(motor_temp_monitor) >= $past(motor_overheat_threshold));
   endproperty
   a_motor_hot: assert property (p_motor_hot) else $error("code 30 wrong");

   property p_off_load;
      @(posedge clk) disable iff (!rst_n_int)
         func_code[otfs_pkg::CODE_W-1:0] == otfs_pkg::FC_OFF_LOAD
         |=> term_out[0] == $past(load_zero);
   endproperty
   a_off_load: assert property (p_off_load) else $error("code 32 wrong");

endmodule

// file: otfs_relay_model.sv
// otfs_relay_model: relay bank wired to the output terminals, the far side of the selector
`timescale 1ns/1ns
module otfs_relay_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // coils from the terminals, contacts and closure count back
   input wire logic [otfs_pkg::NUM_TERM-1:0] coil,
   output logic [otfs_pkg::NUM_TERM-1:0] contact,
   output logic [7:0] close_count
);
   // ***************************************************************
   // contacts
   // ***************************************************************
   // contacts lag the coil by one cycle; counting closures of terminal 0
   // shows a stretched or retriggered pulse as a single event
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         contact <= '0;
         close_count <= 8'h00;
      end else begin
         contact <= coil;
         if (coil[0] && !contact[0]) begin
            close_count <= close_count + 8'h01;
         end
      end
   end
endmodule

// file: tb_otfs_top.sv
// tb_otfs_top: self-checking bench of the output terminal function selector
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
   $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module tb_otfs_top;
   // ***************************************************************
   // signals
   // ***************************************************************
   logic clk, rst_n, running, reverse, at_lower_limit, out_freq_zero, undervolt;
   logic [otfs_pkg::NUM_TERM*otfs_pkg::CODE_W-1:0] func_code;
   logic seq_cycle_done, freq_level_detector_a, freq_level_detector_b, freq_reached;
   logic arb_freq_reached_a, arb_freq_reached_b, curr_reached_a, curr_reached_b;
   logic curr_limit_exceeded, curr_at_or_below_zero_level, run_timer_enable;
   logic drive_overload_warn, motor_overload_warn, load_zero;
   logic [otfs_pkg::CNT_W-1:0] count_value, set_count_target, designated_count_target;
   logic [otfs_pkg::CNT_W-1:0] actual_length, length_target, run_time, run_time_set;
   logic [otfs_pkg::ZC_W-1:0] zero_curr_delay_cyc;
   logic [otfs_pkg::TEMP_W-1:0] heatsink_temp_reading, module_temp_threshold;
   logic [otfs_pkg::TEMP_W-1:0] motor_temp_monitor, motor_overheat_threshold;
   logic [otfs_pkg::NUM_TERM-1:0] term_out, contact;
   logic [7:0] close_count, closes0;
   int fails = 0;
   int checked = 0;
   localparam int ZD = 3;

   otfs_top otfs_top_inst (.clk(clk), .rst_n(rst_n), .func_code(func_code), .running(running),
      .reverse(reverse), .at_lower_limit(at_lower_limit), .out_freq_zero(out_freq_zero),
      .undervolt(undervolt), .count_value(count_value), .set_count_target(set_count_target),
      .designated_count_target(designated_count_target), .actual_length(actual_length),
      .length_target(length_target), .seq_cycle_done(seq_cycle_done),
      .freq_level_detector_a(freq_level_detector_a), .freq_reached(freq_reached),
      .freq_level_detector_b(freq_level_detector_b), .arb_freq_reached_a(arb_freq_reached_a),
      .arb_freq_reached_b(arb_freq_reached_b), .curr_reached_a(curr_reached_a),
      .curr_reached_b(curr_reached_b), .curr_limit_exceeded(curr_limit_exceeded),
      .curr_at_or_below_zero_level(curr_at_or_below_zero_level),
      .zero_curr_delay_cyc(zero_curr_delay_cyc), .heatsink_temp_reading(heatsink_temp_reading),
      .module_temp_threshold(module_temp_threshold), .motor_temp_monitor(motor_temp_monitor),
      .motor_overheat_threshold(motor_overheat_threshold), .run_timer_enable(run_timer_enable),
      .run_time(run_time), .run_time_set(run_time_set), .load_zero(load_zero),
      .drive_overload_warn(drive_overload_warn), .motor_overload_warn(motor_overload_warn),
      .term_out(term_out));

   otfs_relay_model otfs_relay_model_inst (.clk(clk), .rst_n(rst_n), .coil(term_out),
      .contact(contact), .close_count(close_count));

   // ***************************************************************
   // clock, helpers
   // ***************************************************************
   // 10 MHz clock
   always #50 clk = ~clk;

   task go;
      @(posedge clk);
   endtask

   // let the sampling edge pass, then look at the settled outputs
   task settle;
      @(posedge clk);
      @(negedge clk);
   endtask

   task set_code(input int t, input logic [5:0] c);
      func_code[t*otfs_pkg::CODE_W +: otfs_pkg::CODE_W] <= c;
   endtask

   task all_codes(input logic [5:0] c);
      for (int t = 0; t < otfs_pkg::NUM_TERM; t++) begin
         set_code(t, c);
      end
   endtask

   // puts the condition behind code c on (v=1) or just off (v=0); compares sit on the boundary
   task set_cond(input logic [5:0] c, input logic v);
      case (c)
         6'h0A: reverse <= v;
         6'h0D: set_count_target <= v ? 32'h64 : 32'h65;
         6'h0E: designated_count_target <= v ? 32'h64 : 32'h65;
         6'h0F: length_target <= v ? 32'h63 : 32'h64;
         6'h11: freq_level_detector_a <= v;
         6'h12: freq_level_detector_b <= v;
         6'h13: freq_reached <= v;
         6'h14: arb_freq_reached_a <= v;
         6'h15: arb_freq_reached_b <= v;
         6'h16: curr_reached_a <= v;
         6'h17: curr_reached_b <= v;
         6'h18: module_temp_threshold <= v ? 16'h32 : 16'h33;
         6'h19: run_time_set <= v ? 32'h07 : 32'h08;
         6'h1B: curr_limit_exceeded <= v;
         6'h1C: undervolt <= v;
         6'h1D: drive_overload_warn <= v;
         6'h1E: motor_overheat_threshold <= v ? 16'h28 : 16'h29;
         6'h1F: motor_overload_warn <= v;
         6'h20: load_zero <= v;
         default: ;
      endcase
   endtask

   task summarize;
      $display("counts: checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ***************************************************************
   // tests
   // ***************************************************************
   initial begin
      clk = 0; rst_n = 0; running = 1; reverse = 0; at_lower_limit = 0; out_freq_zero = 0;
      undervolt = 1; func_code = {9{6'h1C}}; seq_cycle_done = 0; curr_at_or_below_zero_level = 0;
      count_value = 32'h64; actual_length = 32'h64; heatsink_temp_reading = 16'h32;
      run_time = 32'h07; motor_temp_monitor = 16'h28; run_timer_enable = 1;
      zero_curr_delay_cyc = ZD;
      for (int c = 0; c < 64; c++) set_cond(c[5:0], 1'b0);
      undervolt <= 1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      `CHK("term_out in reset", 9'h000, term_out)
      go;
      rst_n <= 1;
      repeat (2) begin
         settle;
         `CHK("term_out after release", 9'h000, term_out)
      end
      settle;
      `CHK("term_out first sample", 9'h1FF, term_out)
      $display("test reset done");
      // one code on terminal 0 only, condition off then on, other terminals idle
      for (int c = 10; c <= 32; c++) begin
         if (c != 11 && c != 12 && c != 16 && c != 26) begin
            go;
            for (int k = 0; k < 64; k++) set_cond(k[5:0], 1'b0);
            all_codes(6'h00);
            set_code(0, c[5:0]);
            settle;
            `CHK("single off", 9'h000, term_out)
            go;
            set_cond(c[5:0], 1'b1);
            settle;
            `CHK("single on", 9'h001, term_out)
         end
      end
      go;
      set_code(0, 6'h19);
      set_cond(6'h19, 1'b1);
      run_timer_enable <= 0;
      settle;
      `CHK("timing disabled", 9'h000, term_out)
      $display("test single codes done");
      // run state codes side by side on four terminals
      go;
      set_cond(6'h19, 1'b0);
      run_timer_enable <= 1;
      all_codes(6'h00);
      set_code(0, 6'h09);
      set_code(1, 6'h0A);
      set_code(2, 6'h0C);
      set_code(3, 6'h0B);
      reverse <= 1;
      for (int i = 0; i < 8; i++) begin
         go;
         running <= i[0];
         at_lower_limit <= i[1];
         out_freq_zero <= i[2];
         settle;
         `CHK("run state", {5'h00, i[2] & i[0], i[2] | !i[0], i[0], i[1] | !i[0]},
            term_out)
      end
      go;
      all_codes(6'h0B);
      running <= 0;
      settle;
      `CHK("zero run stopped", 9'h000, term_out)
      go;
      all_codes(6'h0C);
      settle;
      `CHK("zero any stopped", 9'h1FF, term_out)
      $display("test run state done");
      // every set_cond condition on, sequencer strobe off; codes outside 9..32 must stay off
      go;
      for (int k = 0; k < 64; k++) set_cond(k[5:0], 1'b1);
      seq_cycle_done <= 0;
      for (int c = 0; c < 64; c++) begin
         if (c < 9 || c > 32) begin
            go;
            all_codes(c[5:0]);
            settle;
            `CHK("unassigned code", 9'h000, term_out)
         end
      end
      go;
      for (int k = 0; k < 64; k++) set_cond(k[5:0], 1'b0);
      $display("test unassigned done");
      // zero current: a burst as long as the delay never shows
      all_codes(6'h1A);
      go;
      curr_at_or_below_zero_level <= 1;
      repeat (ZD) go;
      curr_at_or_below_zero_level <= 0;
      repeat (6) begin
         settle;
         `CHK("zero current burst", 9'h000, term_out)
      end
      go;
      curr_at_or_below_zero_level <= 1;
      repeat (ZD + 2) @(posedge clk);
      @(negedge clk);
      `CHK("zero current early", 9'h000, term_out)
      settle;
      `CHK("zero current on", 9'h1FF, term_out)
      go;
      curr_at_or_below_zero_level <= 0;
      repeat (3) settle;
      `CHK("zero current off", 9'h000, term_out)
      $display("test zero current done");
      // sequencer pulse, retriggered mid-pulse, then cut by a reset
      go;
      all_codes(6'h00);
      set_code(0, 6'h10);
      closes0 = close_count;
      go;
      seq_cycle_done <= 1;
      go;
      seq_cycle_done <= 0;
      @(negedge clk);
      `CHK("pulse early", 9'h000, term_out)
      settle;
      `CHK("pulse start", 9'h001, term_out)
      repeat (50) go;
      seq_cycle_done <= 1;
      go;
      seq_cycle_done <= 0;
      repeat (300) begin
         settle;
         `CHK("pulse held", 9'h001, term_out)
      end
      `CHK("relay closures", closes0 + 8'h01, close_count)
      `CHK("relay contact", 9'h001, contact)
      rst_n <= 0;
      #10;
      `CHK("async reset", 9'h000, term_out)
      go;
      rst_n <= 1;
      repeat (4) settle;
      `CHK("pulse cleared", 9'h000, term_out)
      $display("test pulse done");
      summarize;
   end

   // watchdog well beyond the several hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      $display("FAIL watchdog expected done seen hang");
      summarize;
   end
endmodule
